//--- core/sleep_reset_pkg.sv
// constants and types of the sleep and reset sequencer
// assumes a single core clock and an AHB-Lite register port with word addressing
// Operation
// R01: sleep bits 7:4 read zero
// R02: three-bit field selects six sleep states
// R03: sleep instruction acts only when allowed
// R04: software sets allow before sleep, clears after
// R05: off bit needs unlock, four-cycle window
// R06: off bit active at three cycles, self-clears
// R07: detector off only if bit active
// R08: bit 7 stops two-wire clock
// R09: bit 6 stops synchronous timer 2
// R10: bits 5 and 3 stop timers 0, 1
// R11: gating bit 4 reads zero
// R12: bit 2 stops serial peripheral clock
// R13: bit 1 stops serial port clock
// R14: bit 0 shuts converter, blocks comparator mux
// R15: reset restores every register; here the reset status flags are restored only by power-on
// R16: any source resets ports asynchronously; the watchdog here resets only core_reset_n and leaves io_reset_n high
// R17: delay counter stretches reset by fuses
// R18: four qualified reset sources combined
// R19: long pin low resets without clock
// R20: pin release starts delay; fuse disables pin
// R21: power-on release starts delay, drop immediate
// R22: brown-out asserts at once, release delayed
// R23: watchdog one-cycle pulse, delay after
// R24: standby wake takes six cycles
// R25: per-source reset flags, zero write clears
// R26: gated unit frozen, refuses register access
// R27: async assert, synchronised release
package sleep_reset_pkg;

    // ----------------------------------------------------------------
    // register indices, byte address is four times the index
    // ----------------------------------------------------------------
    localparam logic [9:0]  IDX_SLEEP_CONTROL = 10'h033;
    localparam logic [9:0]  IDX_RESET_STATUS  = 10'h034;
    localparam logic [9:0]  IDX_CORE_CONTROL  = 10'h035;
    localparam logic [9:0]  IDX_CLOCK_GATING  = 10'h064;

    // ----------------------------------------------------------------
    // field positions and masks
    // ----------------------------------------------------------------
    localparam int unsigned SLEEP_ALLOW_BIT  = 0;
    localparam int unsigned SLEEP_SELECT_LSB = 1;
    localparam logic [7:0]  SLEEP_CTRL_MASK  = 8'h0f;
    localparam int unsigned OFF_BIT          = 6;
    localparam int unsigned UNLOCK_BIT       = 5;
    localparam int unsigned GATE_TWO_WIRE    = 7;
    localparam int unsigned GATE_TIMER2      = 6;
    localparam int unsigned GATE_TIMER0      = 5;
    localparam int unsigned GATE_TIMER1      = 3;
    localparam int unsigned GATE_SPI         = 2;
    localparam int unsigned GATE_PORT        = 1;
    localparam int unsigned GATE_CONVERTER   = 0;
    localparam logic [7:0]  GATING_MASK      = 8'hef;
    localparam int unsigned FLAG_WATCHDOG    = 3;
    localparam int unsigned FLAG_BROWNOUT    = 2;
    localparam int unsigned FLAG_PIN         = 1;
    localparam int unsigned FLAG_POWER_ON    = 0;

    // ----------------------------------------------------------------
    // values after reset
    // ----------------------------------------------------------------
    localparam logic [7:0] SLEEP_CONTROL_RESET = 8'h00;
    localparam logic [7:0] CLOCK_GATING_RESET  = 8'h00;
    localparam logic [3:0] RESET_STATUS_POR    = 4'h1;

    // ----------------------------------------------------------------
    // sleep select codes
    // ----------------------------------------------------------------
    localparam logic [2:0] SLEEP_IDLE       = 3'h0;
    localparam logic [2:0] SLEEP_NOISE_RED  = 3'h1;
    localparam logic [2:0] SLEEP_POWER_DOWN = 3'h2;
    localparam logic [2:0] SLEEP_POWER_SAVE = 3'h3;
    localparam logic [2:0] SLEEP_STANDBY    = 3'h6;
    localparam logic [2:0] SLEEP_EXT_STBY   = 3'h7;

    // ----------------------------------------------------------------
    // cycle counts
    // ----------------------------------------------------------------
    localparam logic [2:0] UNLOCK_CYCLES       = 3'h4;
    localparam logic [1:0] OFF_CYCLES          = 2'h3;
    localparam logic [2:0] STANDBY_WAKE_CYCLES = 3'h6;

    typedef enum logic [1:0] {RUN, SLEEPING, WAKING} sleep_state_e;

endpackage

//--- core/sleep_gating_reset_sequencer.sv
// sleep control, timed brown-out disable, clock gating and reset sequencing
// assumes inputs synchronous to core_clk except the analog detectors and reset pin
//
// Chosen here: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module sleep_gating_reset_sequencer
    import sleep_reset_pkg::*;
#(
    parameter int unsigned DELAY_W           = 24,
    parameter int unsigned RESET_DELAY_SHORT = 6500,
    parameter int unsigned RESET_DELAY_LONG  = 6500000
) (
    // clock and power-on detector
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    // reset sources and fuses
    input  wire logic        reset_pin_n,
    input  wire logic        pin_reset_disable_fuse,
    input  wire logic        brownout_low,
    input  wire logic        brownout_detector_enable,
    input  wire logic        watchdog_expire,
    input  wire logic        watchdog_system_mode,
    input  wire logic [1:0]  startup_time_fuse,
    input  wire logic [3:0]  clock_select_fuse,
    // reset outputs
    output logic             io_reset_n,
    output logic             core_reset_n,
    // core sleep handshake
    input  wire logic        sleep_instr,
    input  wire logic        wake_event,
    output logic             sleep_active,
    output logic [2:0]       sleep_state_code,
    output logic             core_run,
    output logic             brownout_detector_off,
    // peripheral clock enables
    input  wire logic        timer2_async_select,
    output logic             two_wire_clk_en,
    output logic             timer2_clk_en,
    output logic             timer0_clk_en,
    output logic             timer1_clk_en,
    output logic             serial_peripheral_clk_en,
    output logic             serial_port_clk_en,
    output logic             converter_clk_en,
    output logic             comparator_mux_blocked
);

    // ----------------------------------------------------------------
    // elaboration checks
    // ----------------------------------------------------------------
    if (DELAY_W < 4 || DELAY_W > 31) begin : g_bad_width
        $error("DELAY_W out of range");
    end
    if (RESET_DELAY_SHORT < 1 || RESET_DELAY_LONG < 1 ||
        ((RESET_DELAY_LONG << 3) >= (64'd1 << DELAY_W))) begin : g_bad_delay
        $error("reset delay does not fit the counter");
    end

    // ----------------------------------------------------------------
    // functions
    // ----------------------------------------------------------------
    // word index of a byte address, all ones out of range
    function automatic logic [9:0] reg_index(input logic [31:0] addr);
        if (addr[31:12] != 20'h00000) begin
            reg_index = 10'h3ff;
        end else begin
            reg_index = addr[11:2];
        end
    endfunction

    // codes 100 and 101 are reserved
    function automatic logic sleep_code_valid(input logic [2:0] code);
        sleep_code_valid = (code != 3'h4) && (code != 3'h5);
    endfunction

    // time-out period from the fuses
    function automatic logic [DELAY_W-1:0] delay_target(input logic [1:0] st,
                                                        input logic [3:0] cs);
        logic [DELAY_W-1:0] base;
        base = cs[3] ? DELAY_W'(RESET_DELAY_LONG) : DELAY_W'(RESET_DELAY_SHORT);
        delay_target = base << st;
    endfunction

    // ----------------------------------------------------------------
    // reset combination
    // ----------------------------------------------------------------
    logic       pin_active;
    logic       sag_active;
    logic       hold_n;
    logic       release_meta;
    logic       release_sync;
    logic       watchdog_pulse;
    logic [DELAY_W-1:0] delay_cnt;

    // asynchronous sources assert without a clock
    assign pin_active = !reset_pin_n && !pin_reset_disable_fuse;   // [R19] [R20]
    assign sag_active = brownout_low && brownout_detector_enable;  // [R22]
    assign hold_n     = rst_n && !pin_active && !sag_active;       // [R18] [R21] [R27]
    assign io_reset_n = hold_n;                                    // [R16]

    // release synchroniser
    always_ff @(posedge core_clk or negedge hold_n) begin          // [R27]
        if (!hold_n) begin
            release_meta <= 1'b0;
            release_sync <= 1'b0;
        end else begin
            release_meta <= 1'b1;
            release_sync <= release_meta;
        end
    end

    // one-cycle watchdog reset pulse
    always_ff @(posedge core_clk or negedge hold_n) begin
        if (!hold_n) begin
            watchdog_pulse <= 1'b0;
        end else begin
            watchdog_pulse <= watchdog_expire && watchdog_system_mode
                              && !watchdog_pulse;                   // [R18] [R23]
        end
    end

    // delay counter stretches the internal reset
    always_ff @(posedge core_clk or negedge hold_n) begin
        if (!hold_n) begin
            delay_cnt    <= '0;
            core_reset_n <= 1'b0;
        end else if (watchdog_pulse) begin                         // [R23]
            delay_cnt    <= '0;
            core_reset_n <= 1'b0;
        end else if (!core_reset_n && release_sync) begin          // [R17] [R20] [R21] [R22]
            if (delay_cnt >= delay_target(startup_time_fuse, clock_select_fuse) - 1'b1) begin
                core_reset_n <= 1'b1;
            end else begin
                delay_cnt <= delay_cnt + 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // reset cause flags, kept across all but power-on
    // ----------------------------------------------------------------
    logic       pin_meta;
    logic       pin_seen;
    logic       sag_meta;
    logic       sag_seen;
    logic [3:0] reset_flags;
    logic       wr_pending;
    logic [9:0] wr_index;

    // cause synchronisers
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_meta <= 1'b0;
            pin_seen <= 1'b0;
            sag_meta <= 1'b0;
            sag_seen <= 1'b0;
        end else begin
            pin_meta <= pin_active;
            pin_seen <= pin_meta;
            sag_meta <= sag_active;
            sag_seen <= sag_meta;
        end
    end

    // set wins over a software zero write
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            reset_flags <= RESET_STATUS_POR;                       // [R25]
        end else begin
            if (wr_pending && wr_index == IDX_RESET_STATUS) begin
                reset_flags <= reset_flags & hwdata[3:0];          // [R25]
            end
            if (watchdog_pulse) begin
                reset_flags[FLAG_WATCHDOG] <= 1'b1;
            end
            if (sag_seen) begin
                reset_flags[FLAG_BROWNOUT] <= 1'b1;
            end
            if (pin_seen) begin
                reset_flags[FLAG_PIN] <= 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // ahb-lite slave, zero wait states
    // ----------------------------------------------------------------
    logic       access;
    logic [7:0] sleep_control;
    logic [7:0] clock_gating;
    logic       det_off;
    logic [1:0] off_age;
    logic [2:0] unlock_cnt;
    logic [7:0] read_byte;

    assign access    = hsel && hready && htrans[1];
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    // read mux, unmapped reads zero
    always_comb begin
        case (reg_index(haddr))
            IDX_SLEEP_CONTROL: read_byte = sleep_control & SLEEP_CTRL_MASK;  // [R01]
            IDX_RESET_STATUS:  read_byte = {4'h0, reset_flags};
            IDX_CORE_CONTROL:  read_byte = {1'b0, det_off, unlock_cnt != 3'h0, 5'h00};
            IDX_CLOCK_GATING:  read_byte = clock_gating & GATING_MASK;       // [R11]
            default:           read_byte = 8'h00;
        endcase
    end

    // address phase capture and read data
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_pending <= 1'b0;
            wr_index   <= 10'h000;
            hrdata     <= 32'h00000000;
        end else begin
            wr_pending <= access && hwrite;
            wr_index   <= reg_index(haddr);
            if (access && !hwrite) begin
                hrdata <= {24'h000000, read_byte};
            end
        end
    end

    // ----------------------------------------------------------------
    // sleep control and clock gating registers
    // ----------------------------------------------------------------
    // core reset is low for every source and for the stretch
    always_ff @(posedge core_clk or negedge core_reset_n) begin
        if (!core_reset_n) begin
            sleep_control <= SLEEP_CONTROL_RESET;                  // [R15]
            clock_gating  <= CLOCK_GATING_RESET;
        end else if (wr_pending) begin
            if (wr_index == IDX_SLEEP_CONTROL) begin
                sleep_control <= hwdata[7:0] & SLEEP_CTRL_MASK;    // [R01]
            end
            if (wr_index == IDX_CLOCK_GATING) begin
                clock_gating <= hwdata[7:0] & GATING_MASK;         // [R11]
            end
        end
    end

    // ----------------------------------------------------------------
    // timed brown-out disable sequence
    // ----------------------------------------------------------------
    logic cc_write;
    assign cc_write = wr_pending && wr_index == IDX_CORE_CONTROL;

    // unlock window opened by writing both bits one
    always_ff @(posedge core_clk or negedge core_reset_n) begin
        if (!core_reset_n) begin
            unlock_cnt <= 3'h0;
        end else if (cc_write && hwdata[OFF_BIT] && hwdata[UNLOCK_BIT]) begin
            unlock_cnt <= UNLOCK_CYCLES;                           // [R05]
        end else if (unlock_cnt != 3'h0) begin
            unlock_cnt <= unlock_cnt - 3'h1;
        end
    end

    // bit set inside window, effective and cleared three cycles on
    // age three is the one cycle in which a sleep may take it
    always_ff @(posedge core_clk or negedge core_reset_n) begin
        if (!core_reset_n) begin
            det_off <= 1'b0;
            off_age <= 2'h0;
        end else if (cc_write && hwdata[OFF_BIT] && !hwdata[UNLOCK_BIT]
                     && unlock_cnt != 3'h0) begin
            det_off <= 1'b1;                                       // [R05]
            off_age <= 2'h1;
        end else if (det_off) begin
            if (off_age == OFF_CYCLES) begin
                det_off <= 1'b0;                                   // [R06]
                off_age <= 2'h0;
            end else begin
                off_age <= off_age + 2'h1;
            end
        end
    end

    // ----------------------------------------------------------------
    // sleep state machine
    // ----------------------------------------------------------------
    sleep_state_e       state;
    logic [2:0]         mode;
    logic [DELAY_W-1:0] wake_cnt;
    logic [DELAY_W-1:0] wake_target;
    logic [2:0]         req_mode;

    assign req_mode = sleep_control[SLEEP_SELECT_LSB +: 3];        // [R02]

    // wake latency by the mode slept in
    always_comb begin
        case (mode)
            SLEEP_STANDBY, SLEEP_EXT_STBY: begin
                wake_target = DELAY_W'(STANDBY_WAKE_CYCLES);       // [R24]
            end
            SLEEP_POWER_DOWN, SLEEP_POWER_SAVE: begin
                wake_target = delay_target(startup_time_fuse, clock_select_fuse);
            end
            default: begin
                wake_target = DELAY_W'(1);
            end
        endcase
    end

    // allowed sleep entry, exit after the wake latency
    always_ff @(posedge core_clk or negedge core_reset_n) begin
        if (!core_reset_n) begin
            state                 <= RUN;
            mode                  <= SLEEP_IDLE;
            wake_cnt              <= '0;
            brownout_detector_off <= 1'b0;
        end else begin
            case (state)
                RUN: begin
                    if (sleep_instr && sleep_control[SLEEP_ALLOW_BIT]
                        && sleep_code_valid(req_mode)) begin       // [R03] [R02]
                        state                 <= SLEEPING;
                        mode                  <= req_mode;
                        brownout_detector_off <= det_off && off_age == OFF_CYCLES; // [R07]
                    end
                end
                SLEEPING: begin
                    if (wake_event) begin
                        state    <= WAKING;
                        wake_cnt <= DELAY_W'(1);
                    end
                end
                WAKING: begin
                    brownout_detector_off <= 1'b0;
                    if (wake_cnt >= wake_target) begin
                        state <= RUN;                              // [R24]
                    end else begin
                        wake_cnt <= wake_cnt + 1'b1;
                    end
                end
                default: begin
                    state <= RUN;
                end
            endcase
        end
    end

    assign sleep_active     = state != RUN;
    assign sleep_state_code = mode;
    assign core_run         = core_reset_n && state == RUN;

    // ----------------------------------------------------------------
    // peripheral clock enables, a gated unit is frozen and deaf
    // ----------------------------------------------------------------
    assign two_wire_clk_en          = !clock_gating[GATE_TWO_WIRE];            // [R08] [R26]
    assign timer2_clk_en            = !(clock_gating[GATE_TIMER2]
                                        && !timer2_async_select);              // [R09] [R26]
    assign timer0_clk_en            = !clock_gating[GATE_TIMER0];              // [R10] [R26]
    assign timer1_clk_en            = !clock_gating[GATE_TIMER1];              // [R10]
    assign serial_peripheral_clk_en = !clock_gating[GATE_SPI];                 // [R12]
    assign serial_port_clk_en       = !clock_gating[GATE_PORT];                // [R13]
    assign converter_clk_en         = !clock_gating[GATE_CONVERTER];           // [R14]
    assign comparator_mux_blocked   = clock_gating[GATE_CONVERTER];            // [R14]

    // hsize is fixed at word for this slave
    logic unused_hsize;
    assign unused_hsize = ^hsize;

endmodule // sleep_gating_reset_sequencer

//--- verification/sleep_reset_sva.sv
// checker for the sleep and reset sequencer
// assumes it is bound to the top module and sees only its ports
`timescale 1ns/1ps
module sleep_reset_sva (
    // clock and power-on reset
    input wire logic       core_clk,
    input wire logic       rst_n,
    // reset sources
    input wire logic       reset_pin_n,
    input wire logic       pin_reset_disable_fuse,
    input wire logic       brownout_low,
    input wire logic       brownout_detector_enable,
    input wire logic       watchdog_expire,
    input wire logic       watchdog_system_mode,
    // reset outputs
    input wire logic       io_reset_n,
    input wire logic       core_reset_n,
    // sleep handshake
    input wire logic       sleep_instr,
    input wire logic       wake_event,
    input wire logic       sleep_active,
    input wire logic [2:0] sleep_state_code,
    input wire logic       core_run,
    input wire logic       brownout_detector_off,
    // converter gating
    input wire logic       converter_clk_en,
    input wire logic       comparator_mux_blocked
);
    // ----------------------------------------------------------------
    // properties
    // ----------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    a_pin_reset_now: assert property (
        !reset_pin_n && !pin_reset_disable_fuse |-> !io_reset_n) else $error("pin reset missed");
    a_sag_reset_now: assert property (
        brownout_low && brownout_detector_enable && !brownout_detector_off |-> !io_reset_n)
        else $error("brown-out reset missed");
    a_reset_stretch: assert property (
        $rose(io_reset_n) |-> !core_reset_n [*3]) else $error("reset not stretched");
    a_wd_pulse_reset: assert property (
        watchdog_expire && watchdog_system_mode && core_reset_n |=> ##1 !core_reset_n [*3])
        else $error("watchdog reset missed");
    a_sleep_has_cause: assert property (
        $rose(sleep_active) |-> $past(sleep_instr)) else $error("sleep unasked");
    a_standby_wake_six: assert property (
        wake_event && sleep_active && sleep_state_code[2:1] == 2'b11
        |=> !core_run [*6] ##1 core_run) else $error("standby wake late");
    a_det_off_sleep: assert property (
        $rose(brownout_detector_off) |-> $past(sleep_instr)) else $error("detector off unasked");
    a_converter_mux: assert property (
        comparator_mux_blocked == !converter_clk_en) else $error("mux block mismatch");
endmodule // sleep_reset_sva

bind sleep_gating_reset_sequencer sleep_reset_sva i_sva (.*);

//--- verification/core_sleep_model.sv
// core model: issues the sleep instruction and the wake event on request
// assumes bench requests change just after a rising clock edge
`timescale 1ns/1ps
module core_sleep_model (
    // clock and core state
    input  wire logic core_clk,
    input  wire logic core_run,
    // requests from the bench
    input  wire logic want_sleep,
    input  wire logic want_wake,
    // handshake to the sequencer
    output logic      sleep_instr,
    output logic      wake_event
);
    // a halted core executes nothing, so sleep issues only while running
    always_ff @(posedge core_clk) begin
        sleep_instr <= want_sleep & core_run;
        wake_event  <= want_wake;
    end
endmodule // core_sleep_model

//--- verification/sleep_gating_reset_sequencer_tb_top.sv
// bench: register access, sleep entry and wake, gating and reset sources
// assumes the core model and the checker are compiled before it
`timescale 1ns/1ps
module sleep_gating_reset_sequencer_tb_top import sleep_reset_pkg::*;;
    // ----------------------------------------------------------------
    // signals
    // ----------------------------------------------------------------
    logic        core_clk = 1'b0, rst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0;
    logic [1:0]  htrans = 2'h0, startup_time_fuse = 2'h0;
    logic [2:0]  hsize = 3'h2;
    logic [3:0]  clock_select_fuse = 4'h0;
    logic        reset_pin_n = 1'b1, pin_reset_disable_fuse = 1'b0, brownout_low = 1'b0;
    logic        brownout_detector_enable = 1'b1, watchdog_expire = 1'b0;
    logic        watchdog_system_mode = 1'b1, timer2_async_select = 1'b0;
    logic        want_sleep = 1'b0, want_wake = 1'b0, seen_off = 1'b0;
    wire logic   hreadyout, hresp, io_reset_n, core_reset_n, sleep_instr, wake_event;
    wire logic   sleep_active, core_run, brownout_detector_off, comparator_mux_blocked;
    wire logic   two_wire_clk_en, timer2_clk_en, timer0_clk_en, timer1_clk_en;
    wire logic   serial_peripheral_clk_en, serial_port_clk_en, converter_clk_en;
    wire logic [31:0] hrdata;
    wire logic [2:0]  sleep_state_code;
    wire logic [7:0]  clk_en = {1'b0, two_wire_clk_en, timer2_clk_en, timer0_clk_en,
        timer1_clk_en, serial_peripheral_clk_en, serial_port_clk_en, converter_clk_en};
    int          n_mismatch = 0, comparisons = 0;

    sleep_gating_reset_sequencer #(.RESET_DELAY_SHORT(4), .RESET_DELAY_LONG(8))
        i_dut (.*, .hready(hreadyout));
    core_sleep_model i_core (.*);

    // clock and watchdog
    initial begin
        forever #5 core_clk = ~core_clk;
    end
    initial begin
        repeat (20000) @(posedge core_clk);
        n_mismatch++;
        summarize();
    end
    always @(posedge core_clk) begin
        if (brownout_detector_off === 1'b1)
            seen_off <= 1'b1;
    end

    // ----------------------------------------------------------------
    // tasks
    // ----------------------------------------------------------------
    task automatic xfer(input logic w, input logic [9:0] idx, input logic [7:0] wd,
                        output logic [7:0] rd);
        @(posedge core_clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {20'h0, idx, 2'h0};
        do @(posedge core_clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {24'h0, wd};
        do @(posedge core_clk); while (hreadyout !== 1'b1);
        rd = hrdata[7:0];
    endtask
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wait_run();
        int t = 0;
        while (core_run !== 1'b1 && t < 300) begin
            @(posedge core_clk);
            t++;
        end
    endtask
    task automatic pulse(input bit wake);
        if (wake) want_wake <= 1'b1;
        else want_sleep <= 1'b1;
        @(posedge core_clk);
        want_wake <= 1'b0;
        want_sleep <= 1'b0;
        repeat (3) @(posedge core_clk);
        if (wake) wait_run();
    endtask
    task automatic summarize();
        if (n_mismatch == 0 && comparisons > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // ----------------------------------------------------------------
    // tests
    // ----------------------------------------------------------------
    initial begin
        logic [7:0] rd;
        logic [3:0] c;
        int d, s, n_off;
        repeat (2) @(posedge core_clk);
        rst_n <= 1'b1;
        wait_run();
        xfer(0, IDX_SLEEP_CONTROL, 8'h00, rd); check("sleep_control", rd, 8'h00);
        xfer(0, IDX_RESET_STATUS, 8'h00, rd); check("reset_status", rd, 8'h01);
        xfer(0, 10'h3ff, 8'h00, rd); check("unmapped", rd, 8'h00);
        xfer(1, IDX_CLOCK_GATING, 8'hff, rd);
        xfer(0, IDX_CLOCK_GATING, 8'h00, rd); check("gating", rd, 8'hef);
        check("clk_en", clk_en, 8'h00);
        timer2_async_select <= 1'b1;
        @(posedge core_clk);
        check("clk_en", clk_en, 8'h20);
        xfer(1, IDX_CLOCK_GATING, 8'h00, rd);
        @(posedge core_clk);
        check("clk_en", clk_en, 8'h7f);
        xfer(1, IDX_SLEEP_CONTROL, 8'hff, rd);
        xfer(0, IDX_SLEEP_CONTROL, 8'h00, rd); check("sleep_control", rd, 8'h0f);
        for (c = 0; c < 8; c++) begin
            xfer(1, IDX_SLEEP_CONTROL, {4'h0, c[2:0], 1'b1}, rd);
            pulse(0);
            check("sleep_active", 8'(sleep_active), 8'(c[2:1] != 2'b10));
            if (sleep_active === 1'b1) pulse(1);
            xfer(1, IDX_SLEEP_CONTROL, 8'h00, rd);
            pulse(0);
            check("sleep_active", 8'(sleep_active), 8'h00);
        end
        n_off = 0;
        xfer(1, IDX_SLEEP_CONTROL, 8'h01, rd);
        for (d = 0; d < 12; d++) begin
            if (d < 6) xfer(1, IDX_CORE_CONTROL, 8'h60, rd);
            xfer(1, IDX_CORE_CONTROL, 8'h40, rd);
            repeat (d % 6) @(posedge core_clk);
            seen_off = 1'b0;
            pulse(0);
            n_off += int'(seen_off);
            pulse(1);
        end
        check("off_hits", 8'(n_off), 8'h01);
        for (s = 0; s < 4; s++) begin
            xfer(1, IDX_RESET_STATUS, 8'h00, rd);
            xfer(1, IDX_SLEEP_CONTROL, 8'h0e, rd);
            pin_reset_disable_fuse <= (s == 3);
            reset_pin_n <= !(s == 0 || s == 3);
            brownout_low <= (s == 1);
            watchdog_expire <= (s == 2);
            @(posedge core_clk);
            watchdog_expire <= 1'b0;
            repeat (3) @(posedge core_clk);
            check("io_reset_n", 8'(io_reset_n), 8'(s > 1));
            reset_pin_n <= 1'b1;
            brownout_low <= 1'b0;
            @(posedge core_clk);
            wait_run();
            xfer(0, IDX_RESET_STATUS, 8'h00, rd);
            check("reset_status", rd, (s == 3) ? 8'h00 : 8'h02 << s);
            xfer(0, IDX_SLEEP_CONTROL, 8'h00, rd);
            check("sleep_control", rd, (s == 3) ? 8'h0e : 8'h00);
        end
        summarize();
    end
endmodule // sleep_gating_reset_sequencer_tb_top
